// ==== hw/cag_pkg.sv ====
// constants, request and result carriers for the address generator
`default_nettype none
package cag_pkg;
    // byte register numbers within a bank
    localparam logic [2:0] REG_X = 3'h0;
    localparam logic [2:0] REG_A = 3'h1;
    localparam logic [2:0] REG_C = 3'h2;
    localparam logic [2:0] REG_B = 3'h3;
    localparam logic [2:0] REG_E = 3'h4;
    localparam logic [2:0] REG_D = 3'h5;
    localparam logic [2:0] REG_L = 3'h6;
    localparam logic [2:0] REG_H = 3'h7;
    // word pair numbers within a bank
    localparam logic [1:0] PAIR_ACC  = 2'h0;
    localparam logic [1:0] PAIR_BC   = 2'h1;
    localparam logic [1:0] PAIR_DE   = 2'h2;
    localparam logic [1:0] PAIR_BASE = 2'h3;

    localparam logic [15:0] PAGE_BASE    = 16'h0800;
    localparam logic [15:0] VEC_BASE     = 16'h0040;
    localparam logic [15:0] VEC_LAST     = 16'h007f;
    localparam logic [6:0]  SADDR_TOP    = 7'h7f;
    localparam logic [7:0]  SADDR_SPLIT  = 8'h20;
    localparam logic [15:0] SADDR_FIRST  = 16'hfe20;
    localparam logic [15:0] SADDR_LAST   = 16'hff1f;
    localparam logic [7:0]  SFR_PAGE     = 8'hff;
    localparam logic [7:0]  SFR_GAP_LO   = 8'hd0;
    localparam logic [7:0]  SFR_GAP_HI   = 8'hdf;
    localparam logic [15:0] PC_RESET     = 16'h0000;

    typedef enum logic [4:0] {
        CAG_OP_SEQ, CAG_OP_ABS, CAG_OP_SHORT_PAGE, CAG_OP_VECTOR,
        CAG_OP_REG_BRANCH, CAG_OP_MULTIPLY, CAG_OP_DIVIDE,
        CAG_OP_DEC_ADJUST, CAG_OP_NIBBLE_ROT, CAG_OP_REG, CAG_OP_PAIR,
        CAG_OP_DIRECT, CAG_OP_SADDR, CAG_OP_SFR, CAG_OP_INDIRECT,
        CAG_OP_BASED, CAG_OP_BASED_IDX
    } cag_op_t;

    typedef enum logic [1:0] {CAG_IDLE, CAG_VEC_LO, CAG_VEC_HI} cag_state_t;

    typedef struct packed {
        cag_op_t     op;
        logic [15:0] imm;     // addr16, addr11 or byte in the low bits
        logic [7:0]  opcode;  // bits 5..1 pick the vector entry
        logic [2:0]  rfield;  // byte register field
        logic [1:0]  pfield;  // pair field
        logic        word;    // word-sized operand
        logic        sel_alt; // [base] vs [DE], B vs C
        logic [2:0]  len;     // instruction length in bytes
    } cag_req_t;

    typedef struct packed {
        logic        ea_valid;
        logic [15:0] ea;
        logic        word;
        logic        align_err;
        logic        range_err;
        logic        byte_en;
        logic [4:0]  byte_sel;  // {bank, register}
        logic        src2_en;
        logic [4:0]  src2_sel;
        logic        pair_en;
        logic [3:0]  pair_sel;  // {bank, pair}
    } cag_res_t;
endpackage : cag_pkg
`default_nettype wire

// ==== hw/cag_addr_gen.sv ====
// branch target and operand address generation for the 8-bit core
`timescale 1ns/1ns
`default_nettype none
module cag_addr_gen (
    input  wire logic                 clk_i,
    input  wire logic                 rst_b_i,
    input  wire logic                 req_valid_i,
    input  wire cag_pkg::cag_req_t    req_i,
    input  wire logic                 bank_select_low_i,
    input  wire logic                 bank_select_high_i,
    input  wire logic [3:0][7:0][7:0] regs_i,
    input  wire logic [7:0]           mem_rdata_i,
    input  wire logic                 mem_rvalid_i,
    output logic                      busy_o,
    output logic                      done_o,
    output logic [15:0]               pc_o,
    output cag_pkg::cag_res_t         res_o,
    output logic                      mem_rd_o,
    output logic [15:0]               mem_addr_o
);
    cag_pkg::cag_state_t state_reg;
    logic [7:0]          vec_lo_reg;
    cag_pkg::cag_res_t   res_next;
    logic [1:0]          bank;
    logic [7:0][7:0]     cur;
    logic [15:0]         acc_pair;
    logic [15:0]         base_pair;
    logic [15:0]         de_pair;
    logic [7:0]          imm8;
    logic [15:0]         vec_addr;
    logic                take;

    assign bank      = {bank_select_high_i, bank_select_low_i};
    assign cur       = regs_i[bank];
    // pair n is {byte 2n+1, byte 2n}: A:X, B:C, D:E, H:L
    assign acc_pair  = {cur[cag_pkg::REG_A], cur[cag_pkg::REG_X]};
    assign de_pair   = {cur[cag_pkg::REG_D], cur[cag_pkg::REG_E]};
    assign base_pair = {cur[cag_pkg::REG_H], cur[cag_pkg::REG_L]};
    assign imm8      = req_i.imm[7:0];
    assign take      = req_valid_i && (state_reg == cag_pkg::CAG_IDLE);
    // entry address is always even, so the high byte sits at +1
    assign vec_addr  = cag_pkg::VEC_BASE
                     | {10'h000, req_i.opcode[5:1], 1'b0};

    // operand decode; evaluated each cycle, captured only on take
    always_comb begin
        res_next = '0;
        res_next.word = req_i.word;
        case (req_i.op)
            cag_pkg::CAG_OP_MULTIPLY: begin
                res_next.byte_en  = 1'b1;
                res_next.byte_sel = {bank, cag_pkg::REG_A};
                res_next.src2_en  = 1'b1;
                res_next.src2_sel = {bank, cag_pkg::REG_X};
                res_next.pair_en  = 1'b1;
                res_next.pair_sel = {bank, cag_pkg::PAIR_ACC};
            end
            cag_pkg::CAG_OP_DIVIDE: begin
                res_next.pair_en  = 1'b1;
                res_next.pair_sel = {bank, cag_pkg::PAIR_ACC};
            end
            cag_pkg::CAG_OP_DEC_ADJUST: begin
                res_next.byte_en  = 1'b1;
                res_next.byte_sel = {bank, cag_pkg::REG_A};
            end
            cag_pkg::CAG_OP_NIBBLE_ROT: begin
                res_next.byte_en  = 1'b1;
                res_next.byte_sel = {bank, cag_pkg::REG_A};
            end
            cag_pkg::CAG_OP_REG: begin
                res_next.byte_en  = 1'b1;
                res_next.byte_sel = {bank, req_i.rfield};
            end
            cag_pkg::CAG_OP_PAIR: begin
                res_next.pair_en  = 1'b1;
                res_next.pair_sel = {bank, req_i.pfield};
            end
            cag_pkg::CAG_OP_DIRECT: begin
                res_next.ea_valid = 1'b1;
                res_next.ea       = req_i.imm;
            end
            cag_pkg::CAG_OP_SADDR: begin
                res_next.ea_valid = 1'b1;
                // low codes fold up above ff00h to close the window
                res_next.ea = {cag_pkg::SADDR_TOP,
                               imm8 < cag_pkg::SADDR_SPLIT,
                               imm8};
                res_next.align_err = req_i.word && imm8[0];
            end
            cag_pkg::CAG_OP_SFR: begin
                res_next.ea_valid  = 1'b1;
                res_next.ea        = {cag_pkg::SFR_PAGE, imm8};
                res_next.range_err = (imm8 >= cag_pkg::SFR_GAP_LO)
                                  && (imm8 <= cag_pkg::SFR_GAP_HI);
                res_next.align_err = req_i.word && imm8[0];
            end
            cag_pkg::CAG_OP_INDIRECT: begin
                res_next.ea_valid = 1'b1;
                res_next.ea = req_i.sel_alt ? base_pair : de_pair;
            end
            cag_pkg::CAG_OP_BASED: begin
                res_next.ea_valid = 1'b1;
                // 16-bit target truncates the carry out on purpose
                res_next.ea = base_pair + {8'h00, imm8};
            end
            cag_pkg::CAG_OP_BASED_IDX: begin
                res_next.ea_valid = 1'b1;
                res_next.ea = base_pair + {8'h00, req_i.sel_alt
                    ? cur[cag_pkg::REG_B] : cur[cag_pkg::REG_C]};
            end
            default: begin
                res_next.word = 1'b0;
            end
        endcase
    end

    // sequencer and program counter
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg  <= cag_pkg::CAG_IDLE;
            pc_o       <= cag_pkg::PC_RESET;
            vec_lo_reg <= 8'h00;
        end else begin
            case (state_reg)
                cag_pkg::CAG_IDLE: begin
                    if (take) begin
                        case (req_i.op)
                            cag_pkg::CAG_OP_SEQ:
                                pc_o <= pc_o + {13'h0000, req_i.len};
                            cag_pkg::CAG_OP_ABS:
                                pc_o <= req_i.imm;
                            cag_pkg::CAG_OP_SHORT_PAGE:
                                pc_o <= cag_pkg::PAGE_BASE
                                      | {5'h00, req_i.imm[10:0]};
                            cag_pkg::CAG_OP_REG_BRANCH:
                                pc_o <= acc_pair;
                            cag_pkg::CAG_OP_VECTOR:
                                state_reg <= cag_pkg::CAG_VEC_LO;
                            default: begin
                                pc_o <= pc_o;
                            end
                        endcase
                    end
                end
                cag_pkg::CAG_VEC_LO: begin
                    if (mem_rvalid_i) begin
                        vec_lo_reg <= mem_rdata_i;
                        state_reg  <= cag_pkg::CAG_VEC_HI;
                    end
                end
                cag_pkg::CAG_VEC_HI: begin
                    if (mem_rvalid_i) begin
                        pc_o      <= {mem_rdata_i, vec_lo_reg};
                        state_reg <= cag_pkg::CAG_IDLE;
                    end
                end
                default: begin
                    state_reg <= cag_pkg::CAG_IDLE;
                end
            endcase
        end
    end

    // memory read strobe holds until each byte is answered
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mem_rd_o   <= 1'b0;
            mem_addr_o <= 16'h0000;
        end else if (take && req_i.op == cag_pkg::CAG_OP_VECTOR) begin
            mem_rd_o   <= 1'b1;
            mem_addr_o <= vec_addr;
        end else if (state_reg == cag_pkg::CAG_VEC_LO && mem_rvalid_i) begin
            mem_addr_o <= mem_addr_o + 16'h0001;
        end else if (state_reg == cag_pkg::CAG_VEC_HI && mem_rvalid_i) begin
            mem_rd_o   <= 1'b0;
        end
    end

    // operand result and handshake flags
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            res_o  <= '0;
            done_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            if (take) begin
                res_o <= res_next;
            end
            done_o <= (take && req_i.op != cag_pkg::CAG_OP_VECTOR)
                   || (state_reg == cag_pkg::CAG_VEC_HI && mem_rvalid_i);
            busy_o <= (take && req_i.op == cag_pkg::CAG_OP_VECTOR)
                   || (state_reg == cag_pkg::CAG_VEC_LO)
                   || (state_reg == cag_pkg::CAG_VEC_HI && !mem_rvalid_i);
        end
    end

    a_abs_pc_load:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_ABS
        |=> pc_o == $past(req_i.imm) && done_o)
        else $error("absolute branch did not load the immediate");

    a_page_call_range:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_SHORT_PAGE
        |=> pc_o >= 16'h0800 && pc_o <= 16'h0fff
            && pc_o[10:0] == $past(req_i.imm[10:0]))
        else $error("short page call target out of its page");

    a_vec_entry_addr:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_VECTOR
        |=> mem_rd_o && busy_o && !mem_addr_o[0]
            && mem_addr_o >= cag_pkg::VEC_BASE
            && mem_addr_o <= cag_pkg::VEC_LAST
            && mem_addr_o[5:1] == $past(req_i.opcode[5:1]))
        else $error("vector entry address wrong");

    a_vec_byte_order:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == cag_pkg::CAG_VEC_LO && mem_rvalid_i
        |=> mem_addr_o == $past(mem_addr_o) + 16'h0001 && mem_rd_o)
        else $error("vector high byte not read at odd address");

    a_vec_pc_load:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        state_reg == cag_pkg::CAG_VEC_HI && mem_rvalid_i
        |=> pc_o[15:8] == $past(mem_rdata_i) && done_o && !busy_o
            && !mem_rd_o)
        else $error("vector entry not loaded into the pc");

    a_reg_branch_pc:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_REG_BRANCH
        |=> pc_o == $past(acc_pair))
        else $error("register branch did not copy the accumulator pair");

    a_seq_advance:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_SEQ
        |=> pc_o == $past(pc_o) + {13'h0000, $past(req_i.len)})
        else $error("pc did not advance by the instruction length");

    a_multiply_implied:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_MULTIPLY
        |=> res_o.byte_sel[2:0] == cag_pkg::REG_A
            && res_o.src2_sel[2:0] == cag_pkg::REG_X
            && res_o.pair_sel[1:0] == cag_pkg::PAIR_ACC
            && res_o.pair_sel[3:2] == $past(bank))
        else $error("multiply operands not implied correctly");

    a_reg_bank_select:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_REG
        |=> res_o.byte_en
            && res_o.byte_sel == {$past(bank_select_high_i),
                                  $past(bank_select_low_i),
                                  $past(req_i.rfield)})
        else $error("register bank or field not honoured");

    a_saddr_window:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_SADDR
        |=> res_o.ea >= cag_pkg::SADDR_FIRST
            && res_o.ea <= cag_pkg::SADDR_LAST
            && res_o.ea[8] == ($past(imm8) < 8'h20))
        else $error("short direct address outside its window");

    a_sfr_gap_flag:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_SFR
        |=> res_o.ea[15:8] == 8'hff
            && res_o.range_err == (res_o.ea >= 16'hffd0
                                   && res_o.ea <= 16'hffdf))
        else $error("special register gap not flagged");

    a_based_sum:
    assert property (@(posedge clk_i) disable iff (!rst_b_i)
        take && req_i.op == cag_pkg::CAG_OP_BASED
        |=> res_o.ea == 16'($past(base_pair) + {8'h00, $past(imm8)}))
        else $error("based address sum wrong");

endmodule : cag_addr_gen
`default_nettype wire

// ==== dv/test_cpu_address_generation.sv ====
// self-checking bench for the address generator, random and corner requests
`timescale 1ns/1ns
`default_nettype none
module test_cpu_address_generation;
    logic                 clk_i = 1'b0;
    logic                 rst_b_i;
    logic                 req_valid_i;
    cag_pkg::cag_req_t    req_i;
    logic                 bank_select_low_i;
    logic                 bank_select_high_i;
    logic [3:0][7:0][7:0] regs_i;
    logic [7:0]           mem_rdata_i;
    logic                 mem_rvalid_i;
    logic                 busy_o;
    logic                 done_o;
    logic [15:0]          pc_o;
    cag_pkg::cag_res_t    res_o;
    logic                 mem_rd_o;
    logic [15:0]          mem_addr_o;
    int                   mismatches = 0;
    int                   checked = 0;
    int                   cycles = 0;
    logic [15:0]          rnd = 16'h0016;
    logic [15:0]          pc_exp;
    logic [7:0]           corner [8] = '{8'h1f, 8'h20, 8'h00, 8'hff,
                                         8'hcf, 8'hd0, 8'hdf, 8'he0};

    cag_addr_gen u_dut (
        .clk_i              (clk_i),
        .rst_b_i            (rst_b_i),
        .req_valid_i        (req_valid_i),
        .req_i              (req_i),
        .bank_select_low_i  (bank_select_low_i),
        .bank_select_high_i (bank_select_high_i),
        .regs_i             (regs_i),
        .mem_rdata_i        (mem_rdata_i),
        .mem_rvalid_i       (mem_rvalid_i),
        .busy_o             (busy_o),
        .done_o             (done_o),
        .pc_o               (pc_o),
        .res_o              (res_o),
        .mem_rd_o           (mem_rd_o),
        .mem_addr_o         (mem_addr_o)
    );

    always #4 clk_i = ~clk_i;

    // the whole run needs about a thousand cycles; this only cuts a hang
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (cycles >= 8000) begin
            mismatches++;
            final_report();
        end
    end

    // low byte codes fold up to the special register end of the window
    function automatic logic [15:0] saddr_exp(input logic [7:0] b);
        return (b < 8'h20) ? 16'hff00 + {8'h00, b} : 16'hfe00 + {8'h00, b};
    endfunction : saddr_exp

    function automatic logic [15:0] rnd16();
        rnd = {rnd[14:0], rnd[15] ^ rnd[13] ^ rnd[12] ^ rnd[10]};
        return rnd;
    endfunction : rnd16

    task automatic check(input string what, input logic [23:0] exp,
                         input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    // one request with fresh registers and bank; hl forces the base pair
    task automatic run_op(input logic [4:0] opv, input logic [15:0] imm,
                          input logic wd, input logic [15:0] hl);
        cag_pkg::cag_req_t    r;
        logic [3:0][7:0][7:0] lr;
        logic [1:0]           bk;
        logic [15:0]          t;
        logic [15:0]          base;
        logic [15:0]          ea;
        logic [5:0]           bs;
        logic [4:0]           ps;
        t = rnd16();
        bk = t[1:0];
        r = '0;
        r.op = cag_pkg::cag_op_t'(opv);
        r.imm = imm;
        r.word = wd;
        r.sel_alt = t[2];
        r.len = {1'b0, t[4:3]} + 3'h1;
        r.rfield = t[7:5];
        r.pfield = t[9:8];
        for (int b = 0; b < 4; b++)
            for (int n = 0; n < 8; n++) begin
                t = rnd16();
                lr[b][n] = t[7:0];
            end
        if (hl != 16'h0000)
            lr[bk][7:6] = hl;
        base = {lr[bk][7], lr[bk][6]};
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        regs_i <= lr;
        {bank_select_high_i, bank_select_low_i} <= bk;
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        ea = 16'h0000;
        bs = {res_o.byte_en, res_o.byte_sel};
        ps = {res_o.pair_en, res_o.pair_sel};
        case (r.op)
            cag_pkg::CAG_OP_SEQ:        pc_exp = pc_exp + {13'h0, r.len};
            cag_pkg::CAG_OP_ABS:        pc_exp = imm;
            cag_pkg::CAG_OP_SHORT_PAGE: pc_exp = {5'h01, imm[10:0]};
            cag_pkg::CAG_OP_REG_BRANCH: pc_exp = {lr[bk][1], lr[bk][0]};
            cag_pkg::CAG_OP_DIRECT:     ea = imm;
            cag_pkg::CAG_OP_SADDR:      ea = saddr_exp(imm[7:0]);
            cag_pkg::CAG_OP_SFR:        ea = {8'hff, imm[7:0]};
            cag_pkg::CAG_OP_INDIRECT:
                ea = r.sel_alt ? base : {lr[bk][5], lr[bk][4]};
            cag_pkg::CAG_OP_BASED:      ea = base + {8'h00, imm[7:0]};
            cag_pkg::CAG_OP_BASED_IDX:
                ea = base + {8'h00, lr[bk][r.sel_alt ? 3 : 2]};
            default: ;
        endcase
        check("done pc", 24'({1'b1, pc_exp}), 24'({done_o, pc_o}));
        // operand address ops sit at the end of the op list
        if (r.op >= cag_pkg::CAG_OP_DIRECT)
            check("ea", 24'({1'b1, ea}),
                  24'({res_o.ea_valid, res_o.ea}));
        // branch ops leave the operand word flag clear
        check("word", 24'(wd && r.op >= cag_pkg::CAG_OP_MULTIPLY),
              24'(res_o.word));
        if (r.op == cag_pkg::CAG_OP_SADDR || r.op == cag_pkg::CAG_OP_SFR)
            check("flags",
                  24'({wd & imm[0],
                       r.op == cag_pkg::CAG_OP_SFR && imm[7:4] == 4'hd}),
                  24'({res_o.align_err, res_o.range_err}));
        case (r.op)
            cag_pkg::CAG_OP_MULTIPLY: begin
                check("mul a", 24'({1'b1, bk, 3'h1}), 24'(bs));
                check("mul x", 24'({1'b1, bk, 3'h0}),
                      24'({res_o.src2_en, res_o.src2_sel}));
                check("mul ax", 24'({1'b1, bk, 2'h0}), 24'(ps));
            end
            cag_pkg::CAG_OP_DIVIDE:
                check("div ax", 24'({1'b1, bk, 2'h0}), 24'(ps));
            cag_pkg::CAG_OP_DEC_ADJUST, cag_pkg::CAG_OP_NIBBLE_ROT:
                check("implied a", 24'({1'b1, bk, 3'h1}),
                      24'(bs));
            cag_pkg::CAG_OP_REG:
                check("reg sel", 24'({1'b1, bk, r.rfield}), 24'(bs));
            cag_pkg::CAG_OP_PAIR:
                check("pair sel", 24'({1'b1, bk, r.pfield}), 24'(ps));
            default: ;
        endcase
    endtask : run_op

    // vector fetch with a request left up while busy, then a stray answer
    task automatic run_vector(input logic [15:0] t);
        cag_pkg::cag_req_t r;
        logic [15:0]       adr;
        logic [15:0]       val;
        r = '0;
        r.op = cag_pkg::CAG_OP_VECTOR;
        r.opcode = {t[15:14], t[4:0], t[13]};
        r.len = 3'h1;
        adr = {8'h00, 2'b01, t[4:0], 1'b0};
        val = rnd16();
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        @(posedge clk_i);
        r.op = cag_pkg::CAG_OP_ABS;
        r.imm = ~val;
        req_i <= r;
        #1;
        check("vec even", 24'({2'b11, adr}),
              24'({busy_o, mem_rd_o, mem_addr_o}));
        repeat (t[6:5]) @(posedge clk_i);
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        mem_rvalid_i <= 1'b1;
        mem_rdata_i <= val[7:0];
        @(posedge clk_i);
        mem_rvalid_i <= 1'b0;
        mem_rdata_i <= ~val[7:0];
        #1;
        check("vec odd", 24'({2'b11, adr + 16'h1}),
              24'({busy_o, mem_rd_o, mem_addr_o}));
        repeat (t[8:7]) @(posedge clk_i);
        @(posedge clk_i);
        mem_rvalid_i <= 1'b1;
        mem_rdata_i <= val[15:8];
        @(posedge clk_i);
        mem_rvalid_i <= 1'b0;
        mem_rdata_i <= ~val[15:8];
        #1;
        pc_exp = val;
        check("vec pc", 24'({3'b100, val}),
              24'({done_o, busy_o, mem_rd_o, pc_o}));
        @(posedge clk_i);
        mem_rvalid_i <= 1'b1;
        @(posedge clk_i);
        mem_rvalid_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check("stray", 24'({3'b000, pc_exp}),
              24'({done_o, busy_o, mem_rd_o, pc_o}));
    endtask : run_vector

    task automatic back_to_back();
        cag_pkg::cag_req_t r;
        r = '0;
        r.op = cag_pkg::CAG_OP_ABS;
        r.imm = rnd16();
        @(posedge clk_i);
        req_valid_i <= 1'b1;
        req_i <= r;
        @(posedge clk_i);
        r.op = cag_pkg::CAG_OP_SEQ;
        r.len = 3'h4;
        req_i <= r;
        #1;
        pc_exp = r.imm;
        check("b2b abs", 24'({1'b1, pc_exp}), 24'({done_o, pc_o}));
        @(posedge clk_i);
        req_valid_i <= 1'b0;
        #1;
        pc_exp = pc_exp + 16'h4;
        check("b2b seq", 24'({1'b1, pc_exp}), 24'({done_o, pc_o}));
        @(posedge clk_i);
        #1;
        check("done drop", 24'h0, 24'(done_o));
    endtask : back_to_back

    initial begin
        logic [15:0] t;
        logic [4:0]  v;
        rst_b_i = 1'b0;
        req_valid_i = 1'b0;
        req_i = '0;
        bank_select_low_i = 1'b0;
        bank_select_high_i = 1'b0;
        regs_i = '0;
        mem_rdata_i = 8'h00;
        mem_rvalid_i = 1'b0;
        pc_exp = 16'h0000;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        #1;
        check("reset", 24'h0,
              24'({busy_o, done_o, mem_rd_o, pc_o}));
        for (int i = 0; i < 8; i++) begin
            run_op(5'd12, {8'h00, corner[i]}, 1'b1, 16'h0);
            run_op(5'd13, {8'h00, corner[i]}, 1'b1, 16'h0);
        end
        run_op(5'd2, 16'hf800, 1'b0, 16'h0);
        run_op(5'd2, 16'h07ff, 1'b0, 16'h0);
        run_op(5'd15, 16'h00ff, 1'b0, 16'hffff);
        run_op(5'd16, 16'h0000, 1'b0, 16'hffff);
        back_to_back();
        // first pass visits every op once, then random ops follow
        for (int i = 0; i < 357; i++) begin
            t = rnd16();
            v = (i < 17) ? 5'(i) : 5'(t % 16'd17);
            if (v == 5'd3)
                run_vector(t);
            else
                run_op(v, rnd16(), t[15], 16'h0);
        end
        final_report();
    end
endmodule : test_cpu_address_generation
`default_nettype wire
